// file: core/mspt_prescale.sv
// two prescaled count enables from the unit clock
// assumes psel fields come from the register block on the same clock
`timescale 1ns/1ps
module mspt_prescale (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       clr,
	input  wire logic [3:0] psel_a,
	input  wire logic [3:0] psel_b,
	output logic            tick_a,
	output logic            tick_b
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        ta;
		logic        tb;
	} mspt_ps_s;

	mspt_ps_s r_reg;
	mspt_ps_s r_next;

	// divide by 2^sel: low bits all ones
	function automatic logic hit(input logic [15:0] c, input logic [3:0] s);
		logic [15:0] m;
		m = (16'h0001 << s) - 16'h0001;
		return (c & m) == m;
	endfunction : hit

	always_comb begin
		r_next     = r_reg;
		r_next.cnt = r_reg.cnt + 16'h0001;
		r_next.ta  = hit(r_reg.cnt, psel_a);
		r_next.tb  = hit(r_reg.cnt, psel_b);
		if (clr) begin
			r_next = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tick_a = r_reg.ta;
	assign tick_b = r_reg.tb;
endmodule : mspt_prescale

// file: core/mspt_slave.sv
// one-count slave channel: duty window counter and active level
// assumes trig is a one-cycle pulse from the master period event
`timescale 1ns/1ps
module mspt_slave (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        clr,
	input  wire logic        tick,
	input  wire logic        run,
	input  wire logic        trig,
	input  wire logic [15:0] reload,
	output logic      [15:0] cnt,
	output logic             act,
	output logic             end_irq
);
	typedef struct packed {
		mspt_pkg::mspt_sl_e st;
		logic [15:0]        cnt;
		logic               act;
		logic               eirq;
	} mspt_sv_s;

	localparam mspt_sv_s RST = '{st: mspt_pkg::SL_IDLE,
		cnt: mspt_pkg::CNT_RST, act: 1'b0, eirq: 1'b0};

	mspt_sv_s r_reg;
	mspt_sv_s r_next;

	always_comb begin
		r_next      = r_reg;
		r_next.eirq = 1'b0;
		if (run && trig) begin
			r_next.cnt = reload;
			r_next.st  = mspt_pkg::SL_ARMED;
		end else if (run && tick) begin
			unique case (r_reg.st)
				mspt_pkg::SL_IDLE: begin
				end
				mspt_pkg::SL_ARMED: begin
					if (r_reg.cnt != mspt_pkg::CNT_RST) begin
						r_next.act = 1'b1;
						r_next.st  = mspt_pkg::SL_COUNT;
					end else begin
						r_next.act  = 1'b0;
						r_next.eirq = 1'b1;
						r_next.st   = mspt_pkg::SL_IDLE;
					end
				end
				mspt_pkg::SL_COUNT: begin
					r_next.cnt = r_reg.cnt - 16'h0001;
					if (r_reg.cnt == 16'h0001) begin
						r_next.act  = 1'b0;
						r_next.eirq = 1'b1;
						r_next.st   = mspt_pkg::SL_IDLE;
					end
				end
				default: begin
					r_next.st = mspt_pkg::SL_IDLE;
				end
			endcase
		end
		if (clr) begin
			r_next = RST;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r_reg <= RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign cnt     = r_reg.cnt;
	assign act     = r_reg.act;
	assign end_irq = r_reg.eirq;
endmodule : mspt_slave

// file: core/mspt_top.sv
// multi-slave pwm timer: axi4-lite registers, master channel, two slaves
// assumes one 25 MHz clock; pwm pins are released while the unit is off
`timescale 1ns/1ps
module mspt_top (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             slave_pwm_pin_1,
	output logic             slave_pwm_pin_1_oe,
	output logic             slave_pwm_pin_2,
	output logic             slave_pwm_pin_2_oe,
	output logic             master_period_irq,
	output logic             slave_end_irq_1,
	output logic             slave_end_irq_2
);
	typedef struct packed {
		logic             unit_en;
		logic [2:0]       run;
		logic [2:0]       cmode;
		logic             msel;
		logic [15:0]      outv;
		logic [15:0]      oute;
		logic [15:0]      outp;
		logic [15:0]      outm;
		logic [7:0]       psel;
		logic [2:0][15:0] rel_sh;
		logic [2:1][15:0] rel_act;
		logic [15:0]      mcnt;
		logic             mirq;
		logic [1:0]       pin;
		logic [7:0]       aw_addr;
		logic             aw_have;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             w_have;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} mspt_top_s;

	mspt_top_s r_reg;
	mspt_top_s r_next;

	logic        tick_a;
	logic        tick_b;
	logic        tick_m;
	logic [15:0] s1_cnt;
	logic [15:0] s2_cnt;
	logic        s1_act;
	logic        s2_act;
	logic        s1_end;
	logic        s2_end;
	logic [31:0] rd_val;
	logic        rd_ok;
	logic [2:0]  start_v;
	logic [2:0]  stop_v;

	// byte-lane merge into a 16-bit field
	function automatic logic [15:0] wmerge(input logic [15:0] o,
		input logic [31:0] d, input logic [3:0] s);
		logic [15:0] v;
		v = o;
		if (s[0]) begin
			v[7:0] = d[7:0];
		end
		if (s[1]) begin
			v[15:8] = d[15:8];
		end
		return v;
	endfunction : wmerge

	assign tick_m = r_reg.cmode[mspt_pkg::CH_M] ? tick_b : tick_a;

	mspt_prescale u_ps (
		.ref_clk (ref_clk),
		.srst    (srst),
		.clr     (~r_reg.unit_en),
		.psel_a  (r_reg.psel[3:0]),
		.psel_b  (r_reg.psel[7:4]),
		.tick_a  (tick_a),
		.tick_b  (tick_b)
	);

	// second slave identical
	// slaves clear on the same edge as the unit, so no late end event
	mspt_slave u_s1 (
		.ref_clk (ref_clk),
		.srst    (srst),
		.clr     (~r_next.unit_en),
		.tick    (r_reg.cmode[mspt_pkg::CH_S1] ? tick_b : tick_a),
		.run     (r_reg.run[mspt_pkg::CH_S1]),
		.trig    (r_reg.mirq),
		.reload  (r_reg.rel_act[1]),
		.cnt     (s1_cnt),
		.act     (s1_act),
		.end_irq (s1_end)
	);

	mspt_slave u_s2 (
		.ref_clk (ref_clk),
		.srst    (srst),
		.clr     (~r_next.unit_en),
		.tick    (r_reg.cmode[mspt_pkg::CH_S2] ? tick_b : tick_a),
		.run     (r_reg.run[mspt_pkg::CH_S2]),
		.trig    (r_reg.mirq),
		.reload  (r_reg.rel_act[2]),
		.cnt     (s2_cnt),
		.act     (s2_act),
		.end_irq (s2_end)
	);

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		case (s_axi_araddr)
			mspt_pkg::OFF_CTRL:  rd_val[0] = r_reg.unit_en;
			mspt_pkg::OFF_TRIG:  rd_val = 32'h0000_0000;
			mspt_pkg::OFF_RUN:   rd_val[2:0] = r_reg.run;
			mspt_pkg::OFF_CMODE: begin
				rd_val[2:0] = r_reg.cmode;
				rd_val[mspt_pkg::CMODE_MSEL_BIT] = r_reg.msel;
			end
			mspt_pkg::OFF_OUTV:  rd_val[15:0] = r_reg.outv;
			mspt_pkg::OFF_OUTE:  rd_val[15:0] = r_reg.oute;
			mspt_pkg::OFF_OUTP:  rd_val[15:0] = r_reg.outp;
			mspt_pkg::OFF_OUTM:  rd_val[15:0] = r_reg.outm;
			mspt_pkg::OFF_REL0:  rd_val[15:0] = r_reg.rel_sh[0];
			mspt_pkg::OFF_REL1:  rd_val[15:0] = r_reg.rel_sh[1];
			mspt_pkg::OFF_REL2:  rd_val[15:0] = r_reg.rel_sh[2];
			mspt_pkg::OFF_CNT0:  rd_val[15:0] = r_reg.mcnt;
			mspt_pkg::OFF_CNT1:  rd_val[15:0] = s1_cnt;
			mspt_pkg::OFF_CNT2:  rd_val[15:0] = s2_cnt;
			mspt_pkg::OFF_PSEL:  rd_val[7:0] = r_reg.psel;
			default:             rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		r_next      = r_reg;
		r_next.mirq = 1'b0;
		start_v     = 3'h0;
		stop_v      = 3'h0;
		if (s_axi_awvalid && !r_reg.aw_have) begin
			r_next.aw_addr = s_axi_awaddr;
			r_next.aw_have = 1'b1;
		end
		if (s_axi_wvalid && !r_reg.w_have) begin
			r_next.w_data = s_axi_wdata;
			r_next.w_strb = s_axi_wstrb;
			r_next.w_have = 1'b1;
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
			r_next.aw_have = 1'b0;
			r_next.w_have  = 1'b0;
			r_next.bvalid  = 1'b1;
			r_next.bresp   = mspt_pkg::RESP_OKAY;
			if (r_reg.aw_addr == mspt_pkg::OFF_CTRL) begin
				if (r_reg.w_strb[0]) begin
					r_next.unit_en = r_reg.w_data[0];
				end
			end else if (r_reg.unit_en) begin
				case (r_reg.aw_addr)
					mspt_pkg::OFF_TRIG: begin
						if (r_reg.w_strb[0]) begin
							start_v = r_reg.w_data[2:0];
							stop_v  = r_reg.w_data[6:4];
						end
					end
					mspt_pkg::OFF_CMODE: begin
						if (r_reg.w_strb[0]) begin
							r_next.cmode = r_reg.w_data[2:0];
						end
						if (r_reg.w_strb[1]) begin
							r_next.msel = r_reg.w_data[8];
						end
					end
					mspt_pkg::OFF_OUTV: r_next.outv =
						wmerge(r_reg.outv, r_reg.w_data, r_reg.w_strb);
					mspt_pkg::OFF_OUTE: r_next.oute =
						wmerge(r_reg.oute, r_reg.w_data, r_reg.w_strb);
					mspt_pkg::OFF_OUTP: r_next.outp =
						wmerge(r_reg.outp, r_reg.w_data, r_reg.w_strb);
					mspt_pkg::OFF_OUTM: r_next.outm =
						wmerge(r_reg.outm, r_reg.w_data, r_reg.w_strb);
					mspt_pkg::OFF_REL0: r_next.rel_sh[0] =
						wmerge(r_reg.rel_sh[0], r_reg.w_data, r_reg.w_strb);
					mspt_pkg::OFF_REL1: r_next.rel_sh[1] =
						wmerge(r_reg.rel_sh[1], r_reg.w_data, r_reg.w_strb);
					mspt_pkg::OFF_REL2: r_next.rel_sh[2] =
						wmerge(r_reg.rel_sh[2], r_reg.w_data, r_reg.w_strb);
					mspt_pkg::OFF_PSEL: begin
						if (r_reg.w_strb[0]) begin
							r_next.psel = r_reg.w_data[7:0];
						end
					end
					mspt_pkg::OFF_CTRL, mspt_pkg::OFF_RUN,
					mspt_pkg::OFF_CNT0, mspt_pkg::OFF_CNT1,
					mspt_pkg::OFF_CNT2: begin
					end
					default: r_next.bresp = mspt_pkg::RESP_SLVERR;
				endcase
			end
		end
		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !r_reg.rvalid) begin
			r_next.rvalid = 1'b1;
			r_next.rdata  = rd_val;
			r_next.rresp  = rd_ok ? mspt_pkg::RESP_OKAY
				: mspt_pkg::RESP_SLVERR;
		end
		r_next.run = r_reg.run & ~stop_v;
		r_next.run = r_next.run | (start_v & ~stop_v);
		if (start_v[mspt_pkg::CH_M] && !stop_v[mspt_pkg::CH_M]) begin
			r_next.mcnt    = r_reg.rel_sh[0];
			r_next.rel_act = r_reg.rel_sh[2:1];
			r_next.mirq    = 1'b1;
		end else if (r_reg.run[mspt_pkg::CH_M] && tick_m
			&& !stop_v[mspt_pkg::CH_M]) begin
			if (r_reg.mcnt == mspt_pkg::CNT_RST) begin
				r_next.mcnt = r_reg.rel_sh[0];
				r_next.rel_act = r_reg.rel_sh[2:1];
				r_next.mirq    = 1'b1;
			end else begin
				r_next.mcnt = r_reg.mcnt - 16'h0001;
			end
		end
		r_next.pin[0] = (r_reg.oute[1] && r_reg.outm[1])
			? (s1_act ^ r_reg.outp[1]) : r_reg.outv[1];
		r_next.pin[1] = (r_reg.oute[2] && r_reg.outm[2])
			? (s2_act ^ r_reg.outp[2]) : r_reg.outv[2];
		if (!r_next.unit_en) begin
			r_next.run     = 3'h0;
			r_next.cmode   = mspt_pkg::CMODE_RST;
			r_next.msel    = 1'b0;
			r_next.outv    = mspt_pkg::OUT_RST;
			r_next.oute    = mspt_pkg::OUT_RST;
			r_next.outp    = mspt_pkg::OUT_RST;
			r_next.outm    = mspt_pkg::OUT_RST;
			r_next.psel    = mspt_pkg::PSEL_RST;
			r_next.rel_sh  = {3{mspt_pkg::REL_RST}};
			r_next.rel_act = {2{mspt_pkg::REL_RST}};
			r_next.mcnt    = mspt_pkg::CNT_RST;
			r_next.mirq    = 1'b0;
			r_next.pin     = 2'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign s_axi_awready      = ~r_reg.aw_have;
	assign s_axi_wready       = ~r_reg.w_have;
	assign s_axi_bvalid       = r_reg.bvalid;
	assign s_axi_bresp        = r_reg.bresp;
	assign s_axi_arready      = ~r_reg.rvalid;
	assign s_axi_rvalid       = r_reg.rvalid;
	assign s_axi_rdata        = r_reg.rdata;
	assign s_axi_rresp        = r_reg.rresp;
	// port mode while the unit is off: pins released
	assign slave_pwm_pin_1    = r_reg.pin[0];
	assign slave_pwm_pin_2    = r_reg.pin[1];
	assign slave_pwm_pin_1_oe = r_reg.unit_en;
	assign slave_pwm_pin_2_oe = r_reg.unit_en;
	assign master_period_irq  = r_reg.mirq;
	assign slave_end_irq_1    = s1_end;
	assign slave_end_irq_2    = s2_end;
endmodule : mspt_top

// file: pkg/mspt_pkg.sv
// constants of the multi-slave pwm timer: register map, fields, resets
// assumes a 32-bit axi4-lite slave with 8-bit byte addresses
package mspt_pkg;
	localparam int          CW            = 16;
	localparam int          AW            = 8;
	// register byte offsets
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_TRIG      = 8'h04;
	localparam logic [7:0]  OFF_RUN       = 8'h08;
	localparam logic [7:0]  OFF_CMODE     = 8'h0C;
	localparam logic [7:0]  OFF_OUTV      = 8'h10;
	localparam logic [7:0]  OFF_OUTE      = 8'h14;
	localparam logic [7:0]  OFF_OUTP      = 8'h18;
	localparam logic [7:0]  OFF_OUTM      = 8'h1C;
	localparam logic [7:0]  OFF_REL0      = 8'h20;
	localparam logic [7:0]  OFF_REL1      = 8'h24;
	localparam logic [7:0]  OFF_REL2      = 8'h28;
	localparam logic [7:0]  OFF_CNT0      = 8'h2C;
	localparam logic [7:0]  OFF_CNT1      = 8'h30;
	localparam logic [7:0]  OFF_CNT2      = 8'h34;
	localparam logic [7:0]  OFF_PSEL      = 8'h38;
	// field positions
	localparam int          TRIG_START_LSB = 0;
	localparam int          TRIG_STOP_LSB  = 4;
	localparam int          CMODE_MSEL_BIT = 8;
	localparam int          PSEL_B_LSB     = 4;
	localparam int          CH_M           = 0;
	localparam int          CH_S1          = 1;
	localparam int          CH_S2          = 2;
	// reset values
	localparam logic [15:0] CNT_RST       = 16'h0000;
	localparam logic [15:0] REL_RST       = 16'h0000;
	localparam logic [15:0] OUT_RST       = 16'h0000;
	localparam logic [7:0]  PSEL_RST      = 8'h00;
	localparam logic [2:0]  CMODE_RST     = 3'h0;
	// bus responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// slave channel states
	typedef enum logic [1:0] {
		SL_IDLE  = 2'b00,
		SL_ARMED = 2'b01,
		SL_COUNT = 2'b10
	} mspt_sl_e;
endpackage : mspt_pkg

// file: testbench/mspt_load_model.sv
// load on the two pwm pins: period length and high time per window
// assumes a pull-down on each pin, so a released pin reads low
`timescale 1ns/1ps
module mspt_load_model (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        period_evt,
	input  wire logic        pin_1,
	input  wire logic        pin_1_oe,
	input  wire logic        pin_2,
	input  wire logic        pin_2_oe,
	output logic      [15:0] period_len,
	output logic      [15:0] high_1,
	output logic      [15:0] high_2
);
	logic [15:0] cyc;
	logic [15:0] acc_1;
	logic [15:0] acc_2;
	logic        lvl_1;
	logic        lvl_2;
	assign lvl_1 = pin_1_oe & pin_1;
	assign lvl_2 = pin_2_oe & pin_2;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cyc <= 16'h0000;
			acc_1 <= 16'h0000;
			acc_2 <= 16'h0000;
		end else if (period_evt) begin
			period_len <= cyc;
			high_1 <= acc_1;
			high_2 <= acc_2;
			cyc <= 16'h0001;
			acc_1 <= {15'h0000, lvl_1};
			acc_2 <= {15'h0000, lvl_2};
		end else begin
			cyc <= cyc + 16'h0001;
			acc_1 <= acc_1 + {15'h0000, lvl_1};
			acc_2 <= acc_2 + {15'h0000, lvl_2};
		end
	end
endmodule : mspt_load_model

// file: testbench/mspt_top_sva.sv
// checker on the bus and pin ports of the multi-slave pwm timer
// assumes it is bound into mspt_top; one clock, synchronous reset
`timescale 1ns/1ps
module mspt_top_chk (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        slave_pwm_pin_1,
	input wire logic        slave_pwm_pin_1_oe,
	input wire logic        slave_pwm_pin_2,
	input wire logic        slave_pwm_pin_2_oe,
	input wire logic        master_period_irq,
	input wire logic        slave_end_irq_1,
	input wire logic        slave_end_irq_2
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	rd_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	rd_done_a: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	rd_err_zero_a: assert property (
		s_axi_rvalid && s_axi_rresp == mspt_pkg::RESP_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("refused read gave data");
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("write answer missing");
	wr_done_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not released");
	irq_unit_on_a: assert property (
		master_period_irq |-> slave_pwm_pin_1_oe && slave_pwm_pin_2_oe)
		else $error("period event with unit off");
	end_unit_on_a: assert property (
		slave_end_irq_1 || slave_end_irq_2 |-> slave_pwm_pin_1_oe)
		else $error("end event with unit off");
	reset_idle_a: assert property (
		$fell(srst) |-> !slave_pwm_pin_1_oe && !slave_pwm_pin_2_oe
		&& !slave_pwm_pin_1 && !slave_pwm_pin_2) else $error("pins busy");
	off_pin_low_a: assert property (
		!slave_pwm_pin_1_oe [*2] |-> !slave_pwm_pin_1)
		else $error("pin level kept with unit off");
	end_pulse_a: assert property (
		slave_end_irq_1 |=> !slave_end_irq_1)
		else $error("end event longer than one cycle");
	period_c: cover property (master_period_irq);
	end_c: cover property (slave_end_irq_2);
	slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : mspt_top_chk

bind mspt_top mspt_top_chk chk_u (.ref_clk, .srst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.slave_pwm_pin_1, .slave_pwm_pin_1_oe, .slave_pwm_pin_2,
	.slave_pwm_pin_2_oe, .master_period_irq, .slave_end_irq_1,
	.slave_end_irq_2);

// file: testbench/mspt_top_test.sv
// register-level tests of the multi-slave pwm timer over axi4-lite
// assumes the load model measures each pwm window on the pins
`timescale 1ns/1ps
module mspt_top_test;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_wvalid = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, master_period_irq;
	logic        slave_end_irq_1, slave_end_irq_2;
	logic        slave_pwm_pin_1, slave_pwm_pin_1_oe;
	logic        slave_pwm_pin_2, slave_pwm_pin_2_oe;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] per, hi_1, hi_2;
	int          n_fail = 0;
	int          n_checks = 0;
	int          cyc_cnt = 0;
	int          n_end = 0;
	always #20 ref_clk = ~ref_clk;
	// bready, rready and wstrb tied: the bench never stalls answers
	mspt_top dut_u (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .slave_pwm_pin_1,
		.slave_pwm_pin_1_oe, .slave_pwm_pin_2, .slave_pwm_pin_2_oe,
		.master_period_irq, .slave_end_irq_1, .slave_end_irq_2);
	mspt_load_model ld_u (.ref_clk(ref_clk), .srst(srst),
		.period_evt(master_period_irq), .pin_1(slave_pwm_pin_1),
		.pin_1_oe(slave_pwm_pin_1_oe), .pin_2(slave_pwm_pin_2),
		.pin_2_oe(slave_pwm_pin_2_oe), .period_len(per), .high_1(hi_1),
		.high_2(hi_2));
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge ref_clk);
			if (!aw_ok && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge ref_clk);
		r = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0]  r;
		rd(a, v, r);
		check(v, exp);
	endtask : rchk
	task automatic wait_irq(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			while (!master_period_irq) @(posedge ref_clk);
		end
		@(posedge ref_clk);
	endtask : wait_irq
	// nba: a read at an edge sees only the end events of earlier edges
	always @(posedge ref_clk) begin
		n_end <= n_end + int'(slave_end_irq_1) + int'(slave_end_irq_2);
	end
	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 6000) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, cyc_cnt, 0);
			final_report();
		end
	end
	initial begin
		logic [1:0]  r;
		logic [31:0] v;
		logic        held;
		int          e0;
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		wr(mspt_pkg::OFF_REL0, 32'h5, r);
		rchk(mspt_pkg::OFF_REL0, 32'h0);
		wr(mspt_pkg::OFF_CTRL, 32'h1, r);
		wr(mspt_pkg::OFF_REL0, 32'h5, r);
		rchk(mspt_pkg::OFF_REL0, 32'h5);
		for (int i = 0; i < 4; i++) begin
			rchk(mspt_pkg::OFF_OUTV + 8'(4 * i), 32'h0);
		end
		wr(8'h3C, 32'h1, r);
		check({30'h0, r}, {30'h0, mspt_pkg::RESP_SLVERR});
		rd(8'h3C, v, r);
		check({30'h0, r}, {30'h0, mspt_pkg::RESP_SLVERR});
		$display("test regs done");
		// master bits kept 0, channel 0 select fixed 0
		wr(mspt_pkg::OFF_OUTM, 32'h6, r);
		wr(mspt_pkg::OFF_OUTP, 32'h4, r);
		wr(mspt_pkg::OFF_OUTE, 32'h6, r);
		wr(mspt_pkg::OFF_CMODE, 32'h0, r);
		wr(mspt_pkg::OFF_REL0, 32'h7, r);
		wr(mspt_pkg::OFF_REL1, 32'h3, r);
		wr(mspt_pkg::OFF_REL2, 32'h6, r);
		wr(mspt_pkg::OFF_TRIG, 32'h7, r);
		rchk(mspt_pkg::OFF_TRIG, 32'h0);
		rchk(mspt_pkg::OFF_RUN, 32'h7);
		e0 = n_end;
		wait_irq(3);
		check(n_end - e0, 32'h6);
		check({16'h0, per}, 32'h8);
		check({16'h0, hi_1}, 32'h3);
		check({16'h0, hi_2}, 32'h2);
		rd(mspt_pkg::OFF_CNT0, v, r);
		check({31'h0, v < 32'h8}, 32'h1);
		$display("test pwm done");
		wait_irq(1);
		wr(mspt_pkg::OFF_REL0, 32'h9, r);
		wr(mspt_pkg::OFF_REL1, 32'h14, r);
		wr(mspt_pkg::OFF_REL2, 32'h0, r);
		wait_irq(3);
		check({16'h0, per}, 32'hA);
		check({16'h0, hi_1}, 32'hA);
		check({16'h0, hi_2}, 32'hA);
		$display("test update done");
		wr(mspt_pkg::OFF_TRIG, 32'h70, r);
		rchk(mspt_pkg::OFF_TRIG, 32'h0);
		rchk(mspt_pkg::OFF_RUN, 32'h0);
		rd(mspt_pkg::OFF_CNT0, v, r);
		held = slave_pwm_pin_1;
		repeat (10) @(posedge ref_clk);
		rchk(mspt_pkg::OFF_CNT0, v);
		check({31'h0, slave_pwm_pin_1}, {31'h0, held});
		wr(mspt_pkg::OFF_OUTE, 32'h0, r);
		wr(mspt_pkg::OFF_OUTV, 32'h2, r);
		repeat (3) @(posedge ref_clk);
		check({31'h0, slave_pwm_pin_1}, 32'h1);
		check({31'h0, slave_pwm_pin_2}, 32'h0);
		$display("test stop done");
		// settings changed only while stopped
		wr(mspt_pkg::OFF_OUTP, 32'h0, r);
		wr(mspt_pkg::OFF_OUTE, 32'h6, r);
		wr(mspt_pkg::OFF_REL0, 32'h7, r);
		wr(mspt_pkg::OFF_REL1, 32'h3, r);
		wr(mspt_pkg::OFF_REL2, 32'h5, r);
		wr(mspt_pkg::OFF_CMODE, 32'h7, r);
		wr(mspt_pkg::OFF_PSEL, 32'h10, r);
		wr(mspt_pkg::OFF_TRIG, 32'h7, r);
		wait_irq(3);
		check({16'h0, per}, 32'h10);
		check({16'h0, hi_1}, 32'h6);
		check({16'h0, hi_2}, 32'hA);
		$display("test clock b done");
		wr(mspt_pkg::OFF_CTRL, 32'h0, r);
		repeat (2) @(posedge ref_clk);
		check({31'h0, slave_pwm_pin_1_oe}, 32'h0);
		check({31'h0, slave_pwm_pin_2_oe}, 32'h0);
		wr(mspt_pkg::OFF_CTRL, 32'h1, r);
		rchk(mspt_pkg::OFF_OUTV, 32'h0);
		rchk(mspt_pkg::OFF_REL0, 32'h0);
		rchk(mspt_pkg::OFF_RUN, 32'h0);
		$display("test unit off done");
		final_report();
	end
endmodule : mspt_top_test
